// >>> dv/serial_center_asserts.sv
`timescale 1ns/10ps
// Watches the pins between the host end and the center end
module serial_center_asserts #(
	parameter int ERR_RESP_LEN = 50
) (
	// Clock and pin reset
	input wire logic clk,
	input wire logic reset,
	input wire logic rst_n,
	// Host-driven pins
	input wire logic cs_n,
	input wire logic wr_n,
	input wire logic [8:1] addr,
	input wire logic host_mode_sel0,
	input wire logic host_mode_sel1,
	input wire logic line_speed_sel0,
	input wire logic line_speed_sel1,
	// Center-driven pins
	input wire logic host_if_busy_n,
	input wire logic serial_out,
	input wire logic tx_enable_high,
	input wire logic tx_enable_low_n,
	input wire logic frame_error_monitor_n,
	input wire logic error_response_monitor_n
);
	int ferr_q;
	int resp_q;
	default clocking @(posedge clk); endclocking
	default disable iff (reset || !rst_n);
	// Low-time counters of the two error monitors
	always_ff @(posedge clk) begin
		ferr_q <= (!rst_n || frame_error_monitor_n) ? 0 : ferr_q + 1;
		resp_q <= (!rst_n || error_response_monitor_n) ? 0 : resp_q + 1;
	end
	property p_tx_pair;
		tx_enable_high == !tx_enable_low_n;
	endproperty
	a_tx_pair: assert property (p_tx_pair) else $error("tx enables disagree");
	property p_busy_on;
		(host_mode_sel1 || host_mode_sel0) && !cs_n && $fell(wr_n) |-> ##[1:2] !host_if_busy_n;
	endproperty
	a_busy_on: assert property (p_busy_on) else $error("busy not raised");
	property p_busy_rel;
		$fell(host_if_busy_n) |-> !host_if_busy_n [*3] ##[1:8] host_if_busy_n;
	endproperty
	a_busy_rel: assert property (p_busy_rel) else $error("busy length wrong");
	property p_no_early;
		$fell(cs_n) |-> host_if_busy_n;
	endproperty
	a_no_early: assert property (p_no_early) else $error("access while busy");
	property p_region;
		!cs_n |-> addr[8:3] == (host_mode_sel1 ? 6'h00 : 6'h3f);
	endproperty
	a_region: assert property (p_region) else $error("upper address level");
	property p_ferr_len;
		$rose(frame_error_monitor_n) |-> ferr_q >= 128;
	endproperty
	a_ferr_len: assert property (p_ferr_len) else $error("error pulse short");
	property p_resp_len;
		$rose(error_response_monitor_n) |-> resp_q >= ERR_RESP_LEN;
	endproperty
	a_resp_len: assert property (p_resp_len) else $error("response pulse short");
	property p_bit_hold;
		$changed(serial_out) && $past(tx_enable_high) && !line_speed_sel1 && !line_speed_sel0
			|=> ($stable(serial_out) || !tx_enable_high) [*8];
	endproperty
	a_bit_hold: assert property (p_bit_hold) else $error("bit too short");
endmodule

// >>> dv/test_serial_center_pin_control.sv
`timescale 1ns/10ps
// Host end facing center end; bench drives both user sides
module test_serial_center_pin_control;
	import serial_center_pkg::*;
	logic clk = 0, reset = 1, req = 0, req_write = 0, ref_is_80 = 0, tx_active = 0, irq = 0;
	logic tx_bit, req_ready, done, work_tick, bit_tick, cmd_write, rx_line, tog;
	logic [4:0] ev = 0;
	logic [1:0] mode_sel = 0, speed_sel = 0, active_mode;
	logic [2:0] req_addr = 0;
	logic [15:0] req_wdata = 0, read_data = 16'ha5c3, rd_data;
	logic [8:0] dec_addr;
	int bad_count = 0, checks_done = 0, ferr_len = 0, resp_len = 0, fr = 0, rr = 0, n, k = 0;
	serial_center_if sc_if();
	always #10 clk = ~clk;
	// Serial data toggles once per bit time, as the core would shift it
	always @(negedge clk) if (bit_tick) k <= k + 1;
	assign tx_bit = k[0];
	serial_center_end #(.ERR_RESP_LEN(50), .TIMEOUT_LEN(20)) serial_center_end_inst (.clk,
		.clk_en(1'b1), .pins(sc_if.center), .tx_active, .tx_bit, .frame_error(ev[0]),
		.response_expected(ev[1]), .response_received(ev[2]), .error_response(ev[3]),
		.cycle_done(ev[4]), .irq, .read_data, .work_tick, .bit_tick, .dec_addr, .cmd_write,
		.active_mode, .rx_line);
	serial_center_host serial_center_host_inst (.clk, .reset, .clk_en(1'b1), .pins(sc_if.host),
		.mode_sel, .speed_sel, .ref_is_80, .req, .req_write, .req_addr, .req_wdata, .req_ready,
		.done, .rd_data);
	serial_center_asserts #(.ERR_RESP_LEN(50)) serial_center_asserts_inst (.clk, .reset,
		.rst_n(sc_if.rst_n), .cs_n(sc_if.cs_n), .wr_n(sc_if.wr_n), .addr(sc_if.addr),
		.host_mode_sel0(sc_if.host_mode_sel0), .host_mode_sel1(sc_if.host_mode_sel1),
		.line_speed_sel0(sc_if.line_speed_sel0), .line_speed_sel1(sc_if.line_speed_sel1),
		.host_if_busy_n(sc_if.host_if_busy_n), .serial_out(sc_if.serial_out),
		.tx_enable_high(sc_if.tx_enable_high), .tx_enable_low_n(sc_if.tx_enable_low_n),
		.frame_error_monitor_n(sc_if.frame_error_monitor_n),
		.error_response_monitor_n(sc_if.error_response_monitor_n));
	// Length of the last low pulse on each error monitor
	always @(posedge clk) begin
		if (sc_if.frame_error_monitor_n && fr != 0) ferr_len = fr;
		fr = sc_if.frame_error_monitor_n ? 0 : fr + 1;
		if (sc_if.error_response_monitor_n && rr != 0) resp_len = rr;
		rr = sc_if.error_response_monitor_n ? 0 : rr + 1;
	end
	task automatic cyc(input int c);
		repeat (c) @(negedge clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("MISMATCH %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic pulse(input int i);
		ev[i] = 1'b1;
		cyc(1);
		ev[i] = 1'b0;
	endtask
	// One host access through the user side, bounded waits
	task automatic access(input logic w, input logic [2:0] a);
		req_write = w;
		req_addr = a;
		req_wdata = 16'h5a00 + a;
		req = 1'b1;
		for (n = 0; n < 50 && req_ready !== 1'b1; n++) cyc(1);
		cyc(1);
		req = 1'b0;
		for (n = 0; n < 50 && done !== 1'b1; n++) begin
			if (sc_if.cs_n === 1'b0) chk(dec_addr[8:3], 0);
			if (sc_if.cs_n === 1'b0) chk(dec_addr[2:0], {a[2:1], mode_sel == 2'b11 && a[0]});
			cyc(1);
		end
		chk(n < 50, 1);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		sc_if.serial_rx_branch_a = 0;
		sc_if.serial_rx_branch_b = 0;
		cyc(12);
		reset = 0;
		cyc(5);
		chk({sc_if.rst_n, sc_if.host_if_busy_n, sc_if.tx_enable_high, sc_if.tx_enable_low_n,
			sc_if.carrier_monitor_n, sc_if.frame_error_monitor_n,
			sc_if.error_response_monitor_n, sc_if.wait_request_out}, 8'h5f);
		cyc(20);
		for (int m = 0; m < 4; m++) begin
			mode_sel = m[1:0];
			cyc(4);
			chk(active_mode, m);
			access(1'b1, 3'h5);
			access(1'b0, 3'h2);
			chk(rd_data, read_data);
		end
		for (int r = 0; r < 2; r++) begin
			for (int s = 0; s < 4; s++) begin
				tx_active = 0;
				ref_is_80 = r[0];
				speed_sel = s[1:0];
				cyc(40);
				tx_active = 1;
				for (n = 0; n < 99 && bit_tick !== 1'b1; n++) cyc(1);
				cyc(1);
				for (n = 1; n < 99 && bit_tick !== 1'b1; n++) cyc(1);
				chk(n, (16 >> s) << r);
			end
		end
		ref_is_80 = 0;
		cyc(40);
		chk({sc_if.tx_enable_high, sc_if.tx_enable_low_n}, 2'b10);
		tx_active = 0;
		cyc(40);
		chk({sc_if.tx_enable_high, sc_if.tx_enable_low_n}, 2'b01);
		irq = 1;
		cyc(2);
		chk(sc_if.int_n, 0);
		irq = 0;
		cyc(2);
		chk(sc_if.int_n, 1);
		for (int b = 0; b < 2; b++) begin
			{sc_if.serial_rx_branch_b, sc_if.serial_rx_branch_a} = 2'b01 << b;
			cyc(3);
			chk(sc_if.carrier_monitor_n, 0);
			{sc_if.serial_rx_branch_b, sc_if.serial_rx_branch_a} = 2'b00;
			cyc(300);
			chk(sc_if.carrier_monitor_n, 1);
		end
		pulse(0);
		cyc(200);
		chk(ferr_len, 128);
		pulse(0);
		cyc(50);
		pulse(0);
		cyc(250);
		chk(ferr_len, 179);
		ferr_len = 0;
		pulse(1);
		cyc(300);
		chk(ferr_len, 128);
		ferr_len = 0;
		pulse(1);
		cyc(5);
		pulse(2);
		cyc(300);
		chk(ferr_len, 0);
		pulse(3);
		cyc(100);
		chk(resp_len, 50);
		tog = sc_if.cycle_toggle_monitor;
		pulse(4);
		cyc(2);
		chk(sc_if.cycle_toggle_monitor, !tog);
		test_done;
	end
	// Cuts a hang short
	initial begin
		#400000;
		bad_count++;
		test_done;
	end
endmodule

// >>> rtl/pulse_stretch.sv
`timescale 1ns/10ps
// Active-low pulse of LEN cycles, restarted by each trigger
module pulse_stretch #(
	parameter int LEN = 128
) (
	// Clock and control
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Trigger and output
	input wire logic trigger,
	output logic pulse_n
);
	localparam int W = $clog2(LEN + 1);
	initial begin
		if (LEN < 1) $error("pulse_stretch LEN must be positive");
	end
	logic [W-1:0] count_q;
	// Reload on trigger, count down otherwise
	always_ff @(posedge clk) begin
		if (reset) begin
			count_q <= '0;
		end else if (clk_en) begin
			if (trigger) count_q <= W'(LEN);
			else if (count_q != '0) count_q <= count_q - 1'b1;
		end
	end
	always_ff @(posedge clk) begin
		if (reset) pulse_n <= 1'b1;
		else if (clk_en) pulse_n <= !(trigger || count_q > W'(1));
	end
endmodule

// >>> rtl/serial_center_cfg.svh
`ifndef SERIAL_CENTER_CFG_SVH
`define SERIAL_CENTER_CFG_SVH
`define WORK_CLK_KHZ 40000
`define FRAME_ERR_CYCLES 128
`define ERR_RESP_MS 200
`define ERR_RESP_CYCLES (`ERR_RESP_MS * (`WORK_CLK_KHZ))
`define RESP_TIMEOUT_NS 20000
`define RESP_TIMEOUT_CYCLES ((`RESP_TIMEOUT_NS * `WORK_CLK_KHZ) / 1000000)
`define RESET_MIN_CYCLES 11
`define MAX_NODES 64
`define ADDR_INV_MASK 9'h1fe
`define REGION_HIGH_BITS 6'h3f
`define REGION_LOW_BITS 6'h00
`define DIV_2P5 4'h0f
`define DIV_5 4'h07
`define DIV_10 4'h03
`define DIV_20 4'h01
`endif

// >>> rtl/serial_center_end.sv
`timescale 1ns/10ps
`include "serial_center_cfg.svh"
// Center device pin control: straps, host busy, line timing and monitors
module serial_center_end
	import serial_center_pkg::*;
#(
	parameter int FRAME_ERR_LEN = `FRAME_ERR_CYCLES,
	parameter int ERR_RESP_LEN = `ERR_RESP_CYCLES,
	parameter int TIMEOUT_LEN = `RESP_TIMEOUT_CYCLES,
	parameter int BUSY_LEN = 4
) (
	// Reference clock and freeze
	input wire logic clk,
	input wire logic clk_en,
	// Pins
	serial_center_if.center pins,
	// Core-side events
	input wire logic tx_active,
	input wire logic tx_bit,
	input wire logic frame_error,
	input wire logic response_expected,
	input wire logic response_received,
	input wire logic error_response,
	input wire logic cycle_done,
	input wire logic irq,
	input wire logic [15:0] read_data,
	// Decoded core view
	output logic work_tick,
	output logic bit_tick,
	output logic [8:0] dec_addr,
	output logic cmd_write,
	output logic [1:0] active_mode,
	output logic rx_line
);
	initial begin
		if (FRAME_ERR_LEN < 1 || ERR_RESP_LEN < 1 || TIMEOUT_LEN < 1 || BUSY_LEN < 1)
			$error("serial_center_end lengths must be positive");
	end
	logic reset;
	logic div_q;
	logic [3:0] bit_cnt_q;
	logic [$clog2(BUSY_LEN+1)-1:0] busy_q;
	logic [$clog2(TIMEOUT_LEN+1)-1:0] wait_q;
	logic strobe_q;
	logic rx_a_q;
	logic rx_b_q;
	logic toggle_q;
	logic [15:0] rdata_q;
	host_mode_t mode;
	line_speed_t speed;
	logic [3:0] div_max;
	logic access;
	logic is_write;
	logic timeout;
	logic err_trig;
	logic busy;
	// Synchronous active-low reset pin
	assign reset = !pins.rst_n;
	// Mode and speed decode from straps
	assign mode = host_mode_t'({pins.host_mode_sel1, pins.host_mode_sel0});
	assign speed = line_speed_t'({pins.line_speed_sel1, pins.line_speed_sel0});
	assign active_mode = mode;
	always_comb begin
		unique case (speed)
			SPD_2P5: div_max = `DIV_2P5;
			SPD_5: div_max = `DIV_5;
			SPD_10: div_max = `DIV_10;
			SPD_20: div_max = `DIV_20;
		endcase
	end
	// Access decode per host bus style
	assign access = !pins.cs_n && ((mode == MODE_1) ? !pins.a0 : (!pins.rd_n || !pins.wr_n));
	assign is_write = !pins.wr_n; // Mode 1 write pin is R/W, low writes; else a write strobe
	assign dec_addr[8:1] = pins.host_mode_sel1 ? pins.addr : ~pins.addr;
	assign dec_addr[0] = (mode == MODE_4) ? pins.a0 : 1'b0;
	assign cmd_write = access && !strobe_q && is_write;
	// Working clock: halve an 80 MHz reference
	assign work_tick = !pins.clock_freq_select || div_q;
	always_ff @(posedge clk) begin
		if (reset) div_q <= 1'b0;
		else if (clk_en) div_q <= !div_q;
	end
	// Bit timing counts working ticks only, so rate ignores reference choice
	assign bit_tick = work_tick && (bit_cnt_q == 4'h0);
	always_ff @(posedge clk) begin
		if (reset) bit_cnt_q <= 4'h0;
		else if (clk_en && work_tick) bit_cnt_q <= (bit_cnt_q == 4'h0) ? div_max : bit_cnt_q - 1'b1;
	end
	// Host busy: low from write command intake until BUSY_LEN working ticks pass
	assign busy = busy_q != '0;
	always_ff @(posedge clk) begin
		if (reset) begin
			busy_q <= '0;
			strobe_q <= 1'b0;
		end else if (clk_en) begin
			strobe_q <= access;
			if (cmd_write) busy_q <= ($bits(busy_q))'(BUSY_LEN);
			else if (busy && work_tick) busy_q <= busy_q - 1'b1;
		end
	end
	// Wait/ready pin follows busy in the mode's polarity
	always_ff @(posedge clk) begin
		if (reset) begin
			pins.host_if_busy_n <= 1'b1;
			pins.wait_request_out <= 1'b1;
		end else if (clk_en) begin
			pins.host_if_busy_n <= !(busy || cmd_write);
			unique case (mode)
				MODE_1: pins.wait_request_out <= !(access && !busy); // Acknowledge
				MODE_3: pins.wait_request_out <= !(busy || cmd_write); // Ready high
				default: pins.wait_request_out <= !(busy || cmd_write); // Wait low
			endcase
		end
	end
	// Read data capture and bus enable
	always_ff @(posedge clk) begin
		if (reset) rdata_q <= 16'h0000;
		else if (clk_en && access && !is_write) rdata_q <= read_data;
	end
	assign pins.rdata = rdata_q;
	assign pins.rdata_oe = access && !is_write;
	assign pins.int_n = !irq;
	// Transmit enables and serial output
	always_ff @(posedge clk) begin
		if (reset) begin
			pins.tx_enable_high <= 1'b0;
			pins.tx_enable_low_n <= 1'b1;
			pins.serial_out <= 1'b0;
		end else if (clk_en) begin
			pins.tx_enable_high <= tx_active;
			pins.tx_enable_low_n <= !tx_active;
			pins.serial_out <= tx_active && tx_bit;
		end
	end
	// Both branches registered alike and merged
	always_ff @(posedge clk) begin
		if (reset) begin
			rx_a_q <= 1'b0;
			rx_b_q <= 1'b0;
		end else if (clk_en) begin
			rx_a_q <= pins.serial_rx_branch_a;
			rx_b_q <= pins.serial_rx_branch_b;
		end
	end
	assign rx_line = rx_a_q | rx_b_q;
	// Carrier: low while line activity seen
	always_ff @(posedge clk) begin
		if (reset) pins.carrier_monitor_n <= 1'b1;
		else if (clk_en) pins.carrier_monitor_n <= !(rx_line || tx_active);
	end
	// Response timeout
	assign timeout = (wait_q == ($bits(wait_q))'(1)) && !response_received;
	always_ff @(posedge clk) begin
		if (reset) wait_q <= '0;
		else if (clk_en) begin
			if (response_expected) wait_q <= ($bits(wait_q))'(TIMEOUT_LEN);
			else if (response_received) wait_q <= '0;
			else if (wait_q != '0 && work_tick) wait_q <= wait_q - 1'b1;
		end
	end
	assign err_trig = frame_error || (timeout && work_tick);
	// Error monitor pulses
	pulse_stretch #(.LEN(FRAME_ERR_LEN)) u_frame_err (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.trigger(err_trig),
		.pulse_n(pins.frame_error_monitor_n)
	);
	pulse_stretch #(.LEN(ERR_RESP_LEN)) u_err_resp (
		.clk(clk),
		.reset(reset),
		.clk_en(clk_en),
		.trigger(error_response),
		.pulse_n(pins.error_response_monitor_n)
	);
	// Cycle monitor toggles on each completed cycle
	always_ff @(posedge clk) begin
		if (reset) toggle_q <= 1'b0;
		else if (clk_en && cycle_done) toggle_q <= !toggle_q;
	end
	assign pins.cycle_toggle_monitor = toggle_q;
endmodule

// >>> rtl/serial_center_host.sv
`timescale 1ns/10ps
`include "serial_center_cfg.svh"
// Host end: drives straps, reset and one access at a time, honouring busy
module serial_center_host
	import serial_center_pkg::*;
(
	// Clock and freeze
	input wire logic clk,
	input wire logic reset,
	input wire logic clk_en,
	// Pins
	serial_center_if.host pins,
	// Straps wanted by the user
	input wire logic [1:0] mode_sel,
	input wire logic [1:0] speed_sel,
	input wire logic ref_is_80,
	// User request
	input wire logic req,
	input wire logic req_write,
	input wire logic [2:0] req_addr,
	input wire logic [15:0] req_wdata,
	output logic req_ready,
	output logic done,
	output logic [15:0] rd_data
);
	typedef enum logic [1:0] {H_RESET, H_IDLE, H_ACCESS, H_HOLD} host_state_t;
	host_state_t state_q;
	logic [3:0] rst_cnt_q;
	logic wr_q;
	logic [2:0] addr_q;
	logic [15:0] wd_q;
	logic region_fill;
	assign region_fill = !mode_sel[1];
	// Straps
	assign pins.host_mode_sel0 = mode_sel[0];
	assign pins.host_mode_sel1 = mode_sel[1];
	assign pins.line_speed_sel0 = speed_sel[0];
	assign pins.line_speed_sel1 = speed_sel[1];
	assign pins.clock_freq_select = ref_is_80;
	assign pins.rst_n = (state_q != H_RESET);
	// Address pins tie upper bits for the small region
	assign pins.addr = {region_fill ? `REGION_HIGH_BITS : `REGION_LOW_BITS,
		region_fill ? ~addr_q[2:1] : addr_q[2:1]};
	// A0 role per mode: strobe, tied high, tied low, byte address
	assign pins.a0 = (mode_sel == 2'b00) ? (state_q != H_ACCESS) :
		(mode_sel == 2'b01) ? 1'b1 : (mode_sel == 2'b10) ? 1'b0 : addr_q[0];
	assign pins.cs_n = !(state_q == H_ACCESS);
	// Mode 1 has no read strobe, its read pin stays high
	assign pins.rd_n = !(state_q == H_ACCESS && !wr_q && mode_sel != 2'b00);
	assign pins.wr_n = !(state_q == H_ACCESS && wr_q);
	assign pins.wdata = wd_q;
	assign req_ready = (state_q == H_IDLE) && pins.host_if_busy_n;
	// Access sequencer
	always_ff @(posedge clk) begin
		if (reset) begin
			state_q <= H_RESET;
			rst_cnt_q <= 4'h0;
			wr_q <= 1'b0;
			addr_q <= 3'h0;
			wd_q <= 16'h0000;
			done <= 1'b0;
			rd_data <= 16'h0000;
		end else if (clk_en) begin
			done <= 1'b0;
			unique case (state_q)
				H_RESET: begin
					rst_cnt_q <= rst_cnt_q + 1'b1;
					if (rst_cnt_q == 4'(`RESET_MIN_CYCLES)) state_q <= H_IDLE;
				end
				H_IDLE: if (req && req_ready) begin
					wr_q <= req_write;
					addr_q <= req_addr;
					wd_q <= req_wdata;
					state_q <= H_ACCESS;
				end
				H_ACCESS: begin
					state_q <= H_HOLD;
				end
				// Read data is registered at the strobe edge, so take it one edge later
				H_HOLD: begin
					if (!wr_q) rd_data <= pins.rdata;
					done <= 1'b1;
					state_q <= H_IDLE;
				end
			endcase
		end
	end
endmodule

// >>> rtl/serial_center_if.sv
`timescale 1ns/10ps
interface serial_center_if;
	logic cs_n;
	logic rd_n;
	logic wr_n;
	logic a0;
	logic [8:1] addr;
	logic [15:0] wdata;
	logic [15:0] rdata;
	logic rdata_oe;
	logic wait_request_out;
	logic host_if_busy_n;
	logic int_n;
	logic host_mode_sel0;
	logic host_mode_sel1;
	logic clock_freq_select;
	logic rst_n;
	logic line_speed_sel0;
	logic line_speed_sel1;
	logic serial_out;
	logic tx_enable_high;
	logic tx_enable_low_n;
	logic serial_rx_branch_a;
	logic serial_rx_branch_b;
	logic carrier_monitor_n;
	logic frame_error_monitor_n;
	logic error_response_monitor_n;
	logic cycle_toggle_monitor;
	modport center (input cs_n, rd_n, wr_n, a0, addr, wdata, host_mode_sel0, host_mode_sel1,
		clock_freq_select, rst_n, line_speed_sel0, line_speed_sel1, serial_rx_branch_a,
		serial_rx_branch_b, output rdata, rdata_oe, wait_request_out, host_if_busy_n, int_n,
		serial_out, tx_enable_high, tx_enable_low_n, carrier_monitor_n, frame_error_monitor_n,
		error_response_monitor_n, cycle_toggle_monitor);
	modport host (output cs_n, rd_n, wr_n, a0, addr, wdata, host_mode_sel0, host_mode_sel1,
		clock_freq_select, rst_n, line_speed_sel0, line_speed_sel1,
		input rdata, rdata_oe, wait_request_out, host_if_busy_n, int_n);
endinterface

// >>> rtl/serial_center_pkg.sv
package serial_center_pkg;
	typedef enum logic [1:0] {MODE_1, MODE_2, MODE_3, MODE_4} host_mode_t;
	typedef enum logic [1:0] {SPD_2P5, SPD_5, SPD_10, SPD_20} line_speed_t;
endpackage
